// >>> hw/irb_bank.sv
// interrupt register bank: normal and fast request banks behind word loads and stores
`timescale 1ns/1ps

module irb_bank #(
    parameter int NSRC = irb_pkg::IRB_SYNC_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // processor register port
    input wire irb_pkg::irb_req_s bus_req,
    output irb_pkg::irb_rsp_s bus_rsp,
    // interrupt sources
    input wire logic [NSRC-1:0] normal_src,
    input wire logic [NSRC-1:0] fast_src,
    // request lines to the processor
    output logic normal_irq,
    output logic fast_irq
);
    import irb_pkg::*;

    // ***************************************************************
    // source capture
    // ***************************************************************
    logic [NSRC-1:0] normal_level;
    logic [NSRC-1:0] fast_level;

    irb_source_sync #(
        .WIDTH(NSRC)
    ) u_normal_sync (
        .mclk(mclk),
        .resetn(resetn),
        .src_async(normal_src),
        .src_level(normal_level)
    );

    irb_source_sync #(
        .WIDTH(NSRC)
    ) u_fast_sync (
        .mclk(mclk),
        .resetn(resetn),
        .src_async(fast_src),
        .src_level(fast_level)
    );

    // ***************************************************************
    // access decode
    // ***************************************************************
    irb_sel_e sel;
    logic wr;
    logic rd;

    // only whole words are decoded; narrower accesses are the processor's concern
    always_comb begin
        sel = irb_decode(bus_req.addr);
        wr = bus_req.valid && bus_req.write;
        rd = bus_req.valid && !bus_req.write;
    end

    // ***************************************************************
    // register state
    // ***************************************************************
    irb_word_t normal_source_enable;
    irb_word_t fast_source_enable;
    irb_word_t software_interrupt_config;
    irb_word_t normal_raw_source_state;
    irb_word_t fast_raw_source_state;
    irb_word_t normal_active_status;
    irb_word_t fast_active_status;

    irb_word_t next_normal_source_enable;
    irb_word_t next_fast_source_enable;
    irb_word_t next_software_interrupt_config;
    irb_word_t next_normal_raw_source_state;
    irb_word_t next_fast_raw_source_state;
    irb_word_t next_normal_active_status;
    irb_word_t next_fast_active_status;
    logic next_normal_irq;
    logic next_fast_irq;
    irb_word_t ext_normal;
    irb_word_t ext_fast;

    always_comb begin
        ext_normal = IRB_READ_ZERO;
        ext_fast = IRB_READ_ZERO;
        ext_normal[NSRC-1:0] = normal_level;
        ext_fast[NSRC-1:0] = fast_level;
        // status and raw registers have no write path at all
        next_normal_source_enable = irb_next_enable(normal_source_enable,
                                                    wr && sel == IRB_SEL_N_EN,
                                                    wr && sel == IRB_SEL_N_DIS,
                                                    bus_req.wdata);
        next_fast_source_enable = irb_next_enable(fast_source_enable,
                                                  wr && sel == IRB_SEL_F_EN,
                                                  wr && sel == IRB_SEL_F_DIS,
                                                  bus_req.wdata);
        next_software_interrupt_config = software_interrupt_config;
        if (wr && sel == IRB_SEL_SWI) begin
            next_software_interrupt_config = bus_req.wdata;
        end
        // programmed interrupts appear as raised sources of the normal bank
        next_normal_raw_source_state = ext_normal | software_interrupt_config;
        next_fast_raw_source_state = ext_fast;
        next_normal_active_status = normal_raw_source_state & normal_source_enable;
        next_fast_active_status = fast_raw_source_state & fast_source_enable;
        next_normal_irq = |next_normal_active_status;
        next_fast_irq = |next_fast_active_status;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            normal_source_enable <= IRB_RST_ENABLE;
            fast_source_enable <= IRB_RST_ENABLE;
            software_interrupt_config <= IRB_RST_SWI;
            normal_raw_source_state <= IRB_RST_STATUS;
            fast_raw_source_state <= IRB_RST_STATUS;
            normal_active_status <= IRB_RST_STATUS;
            fast_active_status <= IRB_RST_STATUS;
            normal_irq <= 1'b0;
            fast_irq <= 1'b0;
        end else begin
            normal_source_enable <= next_normal_source_enable;
            fast_source_enable <= next_fast_source_enable;
            software_interrupt_config <= next_software_interrupt_config;
            normal_raw_source_state <= next_normal_raw_source_state;
            fast_raw_source_state <= next_fast_raw_source_state;
            normal_active_status <= next_normal_active_status;
            fast_active_status <= next_fast_active_status;
            normal_irq <= next_normal_irq;
            fast_irq <= next_fast_irq;
        end
    end

    // ***************************************************************
    // read path
    // ***************************************************************
    irb_rsp_s next_bus_rsp;

    // write-only and unmapped words read as zero
    always_comb begin
        next_bus_rsp.valid = rd;
        next_bus_rsp.rdata = IRB_READ_ZERO;
        if (rd) begin
            case (sel)
                IRB_SEL_N_STA: next_bus_rsp.rdata = normal_active_status;
                IRB_SEL_N_RAW: next_bus_rsp.rdata = normal_raw_source_state;
                IRB_SEL_N_EN: next_bus_rsp.rdata = normal_source_enable;
                IRB_SEL_F_STA: next_bus_rsp.rdata = fast_active_status;
                IRB_SEL_F_RAW: next_bus_rsp.rdata = fast_raw_source_state;
                IRB_SEL_F_EN: next_bus_rsp.rdata = fast_source_enable;
                IRB_SEL_N_DIS: next_bus_rsp.rdata = IRB_READ_ZERO;
                IRB_SEL_F_DIS: next_bus_rsp.rdata = IRB_READ_ZERO;
                default: next_bus_rsp.rdata = IRB_READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_rsp <= '0;
        end else begin
            bus_rsp <= next_bus_rsp;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    property p_status_tracks;
        ##1 1'b1 |-> normal_active_status == $past(normal_raw_source_state & normal_source_enable)
            && fast_active_status == $past(fast_raw_source_state & fast_source_enable);
    endproperty
    a_status_tracks: assert property (p_status_tracks)
        else $error("status not raw and enable");

    property p_irq_line;
        normal_irq == (|normal_active_status) && fast_irq == (|fast_active_status);
    endproperty
    a_irq_line: assert property (p_irq_line)
        else $error("request line disagrees with status");

    property p_raw_tracks;
        ##1 1'b1 |-> fast_raw_source_state[NSRC-1:0] == $past(fast_level)
            && normal_raw_source_state[NSRC-1:0]
               == $past(normal_level | software_interrupt_config[NSRC-1:0]);
    endproperty
    a_raw_tracks: assert property (p_raw_tracks) else $error("raw state not live sources");

    property p_enable_write;
        (wr && sel == IRB_SEL_N_EN) |=> normal_source_enable == $past(bus_req.wdata);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable write not stored");

    property p_disable_write;
        (wr && sel == IRB_SEL_F_DIS)
            |=> fast_source_enable == ($past(fast_source_enable) & ~$past(bus_req.wdata));
    endproperty
    a_disable_write: assert property (p_disable_write)
        else $error("disable did not clear");

    property p_swi_write;
        (wr && sel == IRB_SEL_SWI) |=> software_interrupt_config == $past(bus_req.wdata);
    endproperty
    a_swi_write: assert property (p_swi_write) else $error("software config not stored");

    property p_ro_ignored;
        (wr && (sel == IRB_SEL_N_STA || sel == IRB_SEL_F_RAW || sel == IRB_SEL_NONE))
            |=> $stable(normal_source_enable) && $stable(fast_source_enable)
                && $stable(software_interrupt_config);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored)
        else $error("read-only write changed state");

    property p_readback;
        (rd && sel == IRB_SEL_F_EN)
            |=> bus_rsp.valid && bus_rsp.rdata == $past(fast_source_enable);
    endproperty
    a_readback: assert property (p_readback) else $error("enable readback wrong");

    property p_disable_reads_zero;
        (rd && (sel == IRB_SEL_N_DIS || sel == IRB_SEL_F_DIS))
            |=> bus_rsp.valid && bus_rsp.rdata == IRB_READ_ZERO;
    endproperty
    a_disable_reads_zero: assert property (p_disable_reads_zero)
        else $error("disable read nonzero");

    property p_fast_enable_write;
        (wr && sel == IRB_SEL_F_EN) |=> fast_source_enable == $past(bus_req.wdata);
    endproperty
    a_fast_enable_write: assert property (p_fast_enable_write)
        else $error("fast enable write not stored");

    // the normal enable moves only through its own enable and disable words
    property p_enable_hold;
        !(wr && (sel == IRB_SEL_N_EN || sel == IRB_SEL_N_DIS))
            |=> $stable(normal_source_enable);
    endproperty
    a_enable_hold: assert property (p_enable_hold)
        else $error("normal enable changed without a write");

    property p_normal_disable;
        (wr && sel == IRB_SEL_N_DIS)
            |=> normal_source_enable == ($past(normal_source_enable) & ~$past(bus_req.wdata));
    endproperty
    a_normal_disable: assert property (p_normal_disable)
        else $error("normal disable did not clear ones only");

    property p_swi_reads_zero;
        (rd && sel == IRB_SEL_SWI) |=> bus_rsp.valid && bus_rsp.rdata == IRB_READ_ZERO;
    endproperty
    a_swi_reads_zero: assert property (p_swi_reads_zero)
        else $error("software config read nonzero");

    property p_normal_readback;
        (rd && sel == IRB_SEL_N_EN)
            |=> bus_rsp.valid && bus_rsp.rdata == $past(normal_source_enable);
    endproperty
    a_normal_readback: assert property (p_normal_readback)
        else $error("normal enable readback wrong");

    property p_normal_status_read;
        (rd && sel == IRB_SEL_N_STA) |=> bus_rsp.rdata == $past(normal_active_status);
    endproperty
    a_normal_status_read: assert property (p_normal_status_read)
        else $error("normal status read wrong");

    property p_fast_status_read;
        (rd && sel == IRB_SEL_F_STA) |=> bus_rsp.rdata == $past(fast_active_status);
    endproperty
    a_fast_status_read: assert property (p_fast_status_read)
        else $error("fast status read wrong");

    property p_normal_raw_read;
        (rd && sel == IRB_SEL_N_RAW) |=> bus_rsp.rdata == $past(normal_raw_source_state);
    endproperty
    a_normal_raw_read: assert property (p_normal_raw_read)
        else $error("normal raw read wrong");

    property p_fast_raw_read;
        (rd && sel == IRB_SEL_F_RAW) |=> bus_rsp.rdata == $past(fast_raw_source_state);
    endproperty
    a_fast_raw_read: assert property (p_fast_raw_read)
        else $error("fast raw read wrong");

    property p_cov_normal_irq;
        $rose(normal_irq);
    endproperty
    c_cov_normal_irq: cover property (p_cov_normal_irq);

    property p_cov_fast_irq;
        $rose(fast_irq);
    endproperty
    c_cov_fast_irq: cover property (p_cov_fast_irq);

    property p_cov_disable_drop;
        (wr && sel == IRB_SEL_N_DIS && normal_irq) ##[1:4] !normal_irq;
    endproperty
    c_cov_disable_drop: cover property (p_cov_disable_drop);

    property p_cov_swi_irq;
        (wr && sel == IRB_SEL_SWI) ##[1:4] $rose(normal_irq);
    endproperty
    c_cov_swi_irq: cover property (p_cov_swi_irq);

endmodule

// >>> hw/irb_pkg.sv
// shared constants, field types and decode helpers of the interrupt register bank
package irb_pkg;

    // ***************************************************************
    // widths
    // ***************************************************************
    localparam int IRB_DATA_W = 32;
    localparam int IRB_ADDR_W = 12;
    localparam int IRB_SYNC_W = 32;

    typedef logic [IRB_DATA_W-1:0] irb_word_t;
    typedef logic [IRB_ADDR_W-1:0] irb_addr_t;

    // ***************************************************************
    // register byte offsets within the 4 kB register window
    // ***************************************************************
    localparam irb_addr_t IRB_OFS_NORMAL_ACTIVE_STATUS = 12'h000;
    localparam irb_addr_t IRB_OFS_NORMAL_RAW_SOURCE_STATE = 12'h004;
    localparam irb_addr_t IRB_OFS_NORMAL_SOURCE_ENABLE = 12'h008;
    localparam irb_addr_t IRB_OFS_NORMAL_SOURCE_DISABLE = 12'h00C;
    localparam irb_addr_t IRB_OFS_SOFTWARE_INTERRUPT_CONFIG = 12'h010;
    localparam irb_addr_t IRB_OFS_FAST_ACTIVE_STATUS = 12'h100;
    localparam irb_addr_t IRB_OFS_FAST_RAW_SOURCE_STATE = 12'h104;
    localparam irb_addr_t IRB_OFS_FAST_SOURCE_ENABLE = 12'h108;
    localparam irb_addr_t IRB_OFS_FAST_SOURCE_DISABLE = 12'h10C;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam irb_word_t IRB_RST_ENABLE = 32'h0000_0000;
    localparam irb_word_t IRB_RST_STATUS = 32'h0000_0000;
    localparam irb_word_t IRB_RST_SWI = 32'h0000_0000;
    localparam irb_word_t IRB_READ_ZERO = 32'h0000_0000;

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic valid;
        logic write;
        irb_addr_t addr;
        irb_word_t wdata;
    } irb_req_s;

    typedef struct packed {
        logic valid;
        irb_word_t rdata;
    } irb_rsp_s;

    // register selector decoded from one access
    typedef enum logic [3:0] {
        IRB_SEL_NONE = 4'h0,
        IRB_SEL_N_STA = 4'h1,
        IRB_SEL_N_RAW = 4'h2,
        IRB_SEL_N_EN = 4'h3,
        IRB_SEL_N_DIS = 4'h4,
        IRB_SEL_SWI = 4'h5,
        IRB_SEL_F_STA = 4'h6,
        IRB_SEL_F_RAW = 4'h7,
        IRB_SEL_F_EN = 4'h8,
        IRB_SEL_F_DIS = 4'h9
    } irb_sel_e;

    function automatic irb_sel_e irb_decode(input irb_addr_t addr);
        case (addr)
            IRB_OFS_NORMAL_ACTIVE_STATUS: irb_decode = IRB_SEL_N_STA;
            IRB_OFS_NORMAL_RAW_SOURCE_STATE: irb_decode = IRB_SEL_N_RAW;
            IRB_OFS_NORMAL_SOURCE_ENABLE: irb_decode = IRB_SEL_N_EN;
            IRB_OFS_NORMAL_SOURCE_DISABLE: irb_decode = IRB_SEL_N_DIS;
            IRB_OFS_SOFTWARE_INTERRUPT_CONFIG: irb_decode = IRB_SEL_SWI;
            IRB_OFS_FAST_ACTIVE_STATUS: irb_decode = IRB_SEL_F_STA;
            IRB_OFS_FAST_RAW_SOURCE_STATE: irb_decode = IRB_SEL_F_RAW;
            IRB_OFS_FAST_SOURCE_ENABLE: irb_decode = IRB_SEL_F_EN;
            IRB_OFS_FAST_SOURCE_DISABLE: irb_decode = IRB_SEL_F_DIS;
            default: irb_decode = IRB_SEL_NONE;
        endcase
    endfunction

    // enable update shared by both banks: store on write, clear ones on disable
    function automatic irb_word_t irb_next_enable(input irb_word_t cur, input logic wr_en,
                                                  input logic wr_dis, input irb_word_t wdata);
        if (wr_en) begin
            irb_next_enable = wdata;
        end else if (wr_dis) begin
            irb_next_enable = cur & ~wdata;
        end else begin
            irb_next_enable = cur;
        end
    endfunction

endpackage

// >>> hw/irb_source_sync.sv
// three-stage synchroniser with agreement filter for the interrupt source inputs
`timescale 1ns/1ps

module irb_source_sync #(
    parameter int WIDTH = irb_pkg::IRB_SYNC_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // asynchronous source levels
    input wire logic [WIDTH-1:0] src_async,
    // filtered levels in the mclk domain
    output logic [WIDTH-1:0] src_level
);
    import irb_pkg::*;

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // a bit changes only when the second and third stage agree
    always_comb begin
        next_level = src_level;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_level[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            src_level <= '0;
        end else begin
            stage1 <= src_async;
            stage2 <= stage1;
            stage3 <= stage2;
            src_level <= next_level;
        end
    end

endmodule

// >>> verif/irb_cpu_model.sv
// processor-side model issuing word loads and stores to the register bank
`timescale 1ns/1ps

module irb_cpu_model (
    // clock
    input wire logic mclk,
    // register port request
    output irb_pkg::irb_req_s bus_req
);
    import irb_pkg::*;

    // expected load data, oldest first
    irb_word_t exp_q[$];

    initial bus_req = '0;

    // one request per edge, held until the next call; whole 32-bit words only
    task automatic issue(input logic wr, input irb_addr_t addr, input irb_word_t data,
                         input irb_word_t exp);
        @(posedge mclk);
        bus_req <= '{valid: 1'b1, write: wr, addr: addr, wdata: data};
        if (!wr) begin
            exp_q.push_back(exp);
        end
    endtask

    // idle cycle: qualifiers flip so stale values never look valid
    task automatic rest();
        @(posedge mclk);
        bus_req <= '{valid: 1'b0, write: ~bus_req.write, addr: ~bus_req.addr,
                     wdata: ~bus_req.wdata};
    endtask
endmodule

// >>> verif/tb_top.sv
// self-checking testbench of the interrupt register bank
`timescale 1ns/1ps

module tb_top;
    import irb_pkg::*;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    irb_req_s bus_req;
    irb_rsp_s bus_rsp;
    logic [31:0] normal_src = '0;
    logic [31:0] fast_src = '0;
    logic normal_irq;
    logic fast_irq;
    irb_word_t en_n = '0, en_f = '0, swi = '0, src_n = '0, src_f = '0;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    irb_addr_t addrs[10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                             12'h100, 12'h104, 12'h108, 12'h10C, 12'h014};

    always #5 mclk = ~mclk;

    irb_cpu_model u_cpu (.mclk(mclk), .bus_req(bus_req));

    irb_bank u_dut (.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .normal_src(normal_src), .fast_src(fast_src),
        .normal_irq(normal_irq), .fast_irq(fast_irq));

    // ***************************************************************
    // helpers
    // ***************************************************************
    task automatic tally_and_finish();
        if (u_cpu.exp_q.size() != 0) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, u_cpu.exp_q.size(), 0);
        end
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input irb_word_t got, input irb_word_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic irb_word_t model_rd(input irb_addr_t a);
        case (a)
            IRB_OFS_NORMAL_ACTIVE_STATUS: return (src_n | swi) & en_n;
            IRB_OFS_NORMAL_RAW_SOURCE_STATE: return src_n | swi;
            IRB_OFS_NORMAL_SOURCE_ENABLE: return en_n;
            IRB_OFS_FAST_ACTIVE_STATUS: return src_f & en_f;
            IRB_OFS_FAST_RAW_SOURCE_STATE: return src_f;
            IRB_OFS_FAST_SOURCE_ENABLE: return en_f;
            default: return '0;
        endcase
    endfunction

    // store, then mirror its effect in the reference copy
    task automatic st(input irb_addr_t a, input irb_word_t d);
        u_cpu.issue(1'b1, a, d, '0);
        case (a)
            IRB_OFS_NORMAL_SOURCE_ENABLE: en_n = d;
            IRB_OFS_NORMAL_SOURCE_DISABLE: en_n &= ~d;
            IRB_OFS_SOFTWARE_INTERRUPT_CONFIG: swi = d;
            IRB_OFS_FAST_SOURCE_ENABLE: en_f = d;
            IRB_OFS_FAST_SOURCE_DISABLE: en_f &= ~d;
            default: ;
        endcase
    endtask

    task automatic ld(input irb_addr_t a);
        u_cpu.issue(1'b0, a, $urandom(), model_rd(a));
    endtask

    // long enough for the source path and the enable-to-irq path
    task automatic settle();
        repeat (8) u_cpu.rest();
        @(negedge mclk);
        chk({31'h0, normal_irq}, {31'h0, |((src_n | swi) & en_n)});
        chk({31'h0, fast_irq}, {31'h0, |(src_f & en_f)});
    endtask

    // back-to-back loads of every register and one unmapped word
    task automatic ld_all();
        settle();
        foreach (addrs[i]) begin
            ld(addrs[i]);
        end
        repeat (3) u_cpu.rest();
    endtask

    task automatic drive_src(input irb_word_t n, input irb_word_t f);
        u_cpu.rest();
        normal_src <= n;
        fast_src <= f;
        src_n = n;
        src_f = f;
    endtask

    // ***************************************************************
    // response watcher and timeout
    // ***************************************************************
    // falling edge: the registered response has settled by then
    always @(negedge mclk) begin
        cycles++;
        if (bus_rsp.valid === 1'b1) begin
            if (u_cpu.exp_q.size() == 0) begin
                failures++;
                $display("Error at %0t: got %h expected %h", $time, bus_rsp.rdata, 32'h0);
            end else begin
                chk(bus_rsp.rdata, u_cpu.exp_q.pop_front());
            end
        end else if (resetn === 1'b1) begin
            chk(bus_rsp.rdata, '0);
        end
        if (cycles == 3000) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, cycles, 0);
            tally_and_finish();
        end
    end

    // ***************************************************************
    // scenarios
    // ***************************************************************
    initial begin
        void'($urandom(4));
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        ld_all();
        for (int i = 0; i < 6; i++) begin
            st(IRB_OFS_NORMAL_SOURCE_ENABLE, $urandom());
            st(IRB_OFS_FAST_SOURCE_ENABLE, $urandom());
            drive_src($urandom(), $urandom());
            ld_all();
        end
        // read-only and unmapped places must not move
        drive_src(32'hFFFF_FFFF, 32'h8000_0001);
        st(IRB_OFS_NORMAL_SOURCE_ENABLE, 32'hFFFF_FFFF);
        st(IRB_OFS_FAST_SOURCE_ENABLE, 32'hFFFF_FFFF);
        foreach (addrs[i]) begin
            if (i == 0 || i == 1 || i == 5 || i == 6 || i == 9) begin
                st(addrs[i], 32'h0000_0000);
            end
        end
        ld_all();
        // disable clears only ones, back-to-back with the enable readback
        st(IRB_OFS_NORMAL_SOURCE_DISABLE, 32'h0000_F00F);
        st(IRB_OFS_FAST_SOURCE_DISABLE, 32'hFFFF_FFFF);
        st(IRB_OFS_NORMAL_SOURCE_DISABLE, 32'h0000_0000);
        ld(IRB_OFS_NORMAL_SOURCE_ENABLE);
        ld(IRB_OFS_FAST_SOURCE_ENABLE);
        ld_all();
        // software-raised interrupts on the normal path
        drive_src(32'h0000_0000, 32'h0000_0000);
        st(IRB_OFS_NORMAL_SOURCE_ENABLE, 32'h0000_00F0);
        st(IRB_OFS_SOFTWARE_INTERRUPT_CONFIG, 32'h0000_0030);
        ld_all();
        st(IRB_OFS_SOFTWARE_INTERRUPT_CONFIG, 32'h0000_0003);
        ld_all();
        // second reset in mid-run clears enables and software config
        drive_src(32'h00FF_00FF, 32'hF0F0_F0F0);
        st(IRB_OFS_FAST_SOURCE_ENABLE, 32'hFFFF_0000);
        u_cpu.rest();
        resetn <= 1'b0;
        u_cpu.rest();
        resetn <= 1'b1;
        en_n = '0;
        en_f = '0;
        swi = '0;
        ld_all();
        tally_and_finish();
    end
endmodule
